/* es_pkg.sv */
// Purpose: constants and types for the eye scan configuration register group
// Assumes: 16-bit registers at word addresses 0x56 to 0x5d of the serial control port
// Notes: reset words include the reserved bits so read-back matches a fresh part
package es_pkg;

  localparam int ES_NUM_REGS = 8;
  localparam logic [7:0] ES_BASE_ADDR = 8'h56;
  localparam logic [7:0] ES_ADDR_THRESHOLD = 8'h56;
  localparam logic [7:0] ES_ADDR_SLICE_INIT = 8'h57;
  localparam logic [7:0] ES_ADDR_RESERVED_WORD_A_A = 8'h58;
  localparam logic [7:0] ES_ADDR_RESERVED_WORD_A_B = 8'h59;
  localparam logic [7:0] ES_ADDR_PHASE_RANGE = 8'h5a;
  localparam logic [7:0] ES_ADDR_PHASE_STEP = 8'h5b;
  localparam logic [7:0] ES_ADDR_VERT_LIMIT = 8'h5c;
  localparam logic [7:0] ES_ADDR_SCAN_MODE = 8'h5d;

  // Word indices, address minus base
  localparam int ES_IDX_THRESHOLD = 0;
  localparam int ES_IDX_SLICE_INIT = 1;
  localparam int ES_IDX_PHASE_RANGE = 4;
  localparam int ES_IDX_PHASE_STEP = 5;
  localparam int ES_IDX_VERT_LIMIT = 6;
  localparam int ES_IDX_SCAN_MODE = 7;

  localparam logic [15:0] ES_RST_THRESHOLD = 16'h0064;
  localparam logic [15:0] ES_RST_SLICE_INIT = 16'h8002;
  localparam logic [15:0] ES_RST_RESERVED_WORD_A_A = 16'hd982;
  localparam logic [15:0] ES_RST_RESERVED_WORD_A_B = 16'h0100;
  localparam logic [15:0] ES_RST_PHASE_RANGE = 16'h007f;
  localparam logic [15:0] ES_RST_PHASE_STEP = 16'h0100;
  localparam logic [15:0] ES_RST_VERT_LIMIT = 16'hff01;
  localparam logic [15:0] ES_RST_SCAN_MODE = 16'h0000;

  localparam logic [ES_NUM_REGS-1:0][15:0] ES_RESET_WORDS = {
    ES_RST_SCAN_MODE, ES_RST_VERT_LIMIT, ES_RST_PHASE_STEP, ES_RST_PHASE_RANGE,
    ES_RST_RESERVED_WORD_A_B, ES_RST_RESERVED_WORD_A_A, ES_RST_SLICE_INIT, ES_RST_THRESHOLD};

  // Field positions
  localparam int ES_SLICE_LSB = 8;
  localparam int ES_INIT_BIT = 2;
  localparam int ES_PHASE_FIRST_LSB = 8;
  localparam int ES_PHASE_LAST_LSB = 0;
  localparam int ES_PHASE_STEP_LSB = 8;
  localparam int ES_VERT_FIRST_LSB = 0;
  localparam int ES_VERT_LAST_LSB = 8;
  localparam int ES_VERT_STEP_LSB = 0;
  localparam int ES_SHAPE_BIT = 8;

  // Slice code of the zero-volt level
  localparam logic [7:0] ES_SLICE_ZERO = 8'h80;
  localparam logic [15:0] ES_READ_IDLE = 16'h0000;

  typedef struct packed {
    logic shape_mode;
    logic [15:0] error_count_threshold;
    logic [7:0] default_vertical_slice;
    logic [6:0] phase_first;
    logic [6:0] phase_last;
    logic [6:0] phase_increment;
    logic [6:0] vertical_sweep_first;
    logic [7:0] vertical_sweep_last;
    logic [6:0] vertical_sweep_increment;
  } es_scan_cfg_s;

endpackage

/* es_eye_scan_config_regs.sv */
// Purpose: eye monitor configuration registers with a per-scan snapshot
// Assumes: register port already decoded from the serial control interface, same clock
// Notes: all stored bits, reserved ones included, are read-write and read back
// Behaviour
// - 16-bit error threshold, reset 0x64, classifies points
// - 8-bit default slice in upper byte
// - Slice codes monotonic, 128 is zero volts
// - Phase start bits 14:8, reset zero
// - Phase limit bits 6:0, reset 0x7f
// - Phase step bits 14:8, reset 1, legal 1/2/4
// - Vertical start 6:0 reset 0, limit 15:8 reset 0xff
// - Vertical step bits 6:0, reset 1, legal 1/2/4
// - Mode bit selects eye scan or shape capture
`timescale 1ns/1ps
`default_nettype none

module es_eye_scan_config_regs
  import es_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  // Eye monitor side
  input wire logic scan_start,
  input wire logic err_valid,
  input wire logic [15:0] err_count,
  output logic eye_init,
  output es_scan_cfg_s scan_cfg,
  output logic [7:0] slice_level,
  output logic point_valid,
  output logic point_bad
);

  logic [ES_NUM_REGS-1:0][15:0] words;
  logic [15:0] next_rd_data;
  logic next_rd_valid;
  es_scan_cfg_s next_scan_cfg;
  es_scan_cfg_s live_cfg;
  logic [7:0] next_slice_level;
  logic next_point_valid;
  logic next_point_bad;

  // Storage words, one per address
  for (genvar gi = 0; gi < ES_NUM_REGS; gi++) begin : g_word
    logic [15:0] next_word;
    always_comb begin
      next_word = words[gi];
      if (reg_wr_en && reg_addr == ES_BASE_ADDR + 8'(gi)) begin
        next_word = reg_wr_data;
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        words[gi] <= ES_RESET_WORDS[gi];
      end else begin
        words[gi] <= next_word;
      end
    end
  end

  // Read path, unmapped addresses read zero
  always_comb begin
    next_rd_valid = reg_rd_en;
    next_rd_data = reg_rd_en ? ES_READ_IDLE : reg_rd_data;
    if (reg_rd_en && reg_addr >= ES_BASE_ADDR
        && reg_addr < ES_BASE_ADDR + 8'(ES_NUM_REGS)) begin
      next_rd_data = words[3'(reg_addr - ES_BASE_ADDR)];
    end
  end

  always_comb begin
    live_cfg.error_count_threshold = words[ES_IDX_THRESHOLD];
    live_cfg.default_vertical_slice = words[ES_IDX_SLICE_INIT][ES_SLICE_LSB +: 8];
    live_cfg.phase_first = words[ES_IDX_PHASE_RANGE][ES_PHASE_FIRST_LSB +: 7];
    live_cfg.phase_last = words[ES_IDX_PHASE_RANGE][ES_PHASE_LAST_LSB +: 7];
    live_cfg.phase_increment = words[ES_IDX_PHASE_STEP][ES_PHASE_STEP_LSB +: 7];
    live_cfg.vertical_sweep_first = words[ES_IDX_PHASE_STEP][ES_VERT_FIRST_LSB +: 7];
    live_cfg.vertical_sweep_last = words[ES_IDX_VERT_LIMIT][ES_VERT_LAST_LSB +: 8];
    live_cfg.vertical_sweep_increment = words[ES_IDX_VERT_LIMIT][ES_VERT_STEP_LSB +: 7];
    live_cfg.shape_mode = words[ES_IDX_SCAN_MODE][ES_SHAPE_BIT];
  end

  always_comb begin
    next_scan_cfg = scan_start ? live_cfg : scan_cfg;
    // zero-volt code maps to signed zero
    next_slice_level = scan_start ? (live_cfg.default_vertical_slice ^ ES_SLICE_ZERO)
                                  : slice_level;
  end

  always_comb begin
    next_point_valid = err_valid;
    next_point_bad = err_valid ? (err_count > scan_cfg.error_count_threshold) : point_bad;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rd_data <= ES_READ_IDLE;
      reg_rd_valid <= 1'b0;
      scan_cfg <= '0;
      slice_level <= '0;
      point_valid <= 1'b0;
      point_bad <= 1'b0;
    end else begin
      reg_rd_data <= next_rd_data;
      reg_rd_valid <= next_rd_valid;
      scan_cfg <= next_scan_cfg;
      slice_level <= next_slice_level;
      point_valid <= next_point_valid;
      point_bad <= next_point_bad;
    end
  end

  // Init bit is a stored flop; the host owns its sequencing
  assign eye_init = words[ES_IDX_SLICE_INIT][ES_INIT_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_start;
    scan_start;
  endsequence

  sequence s_quiet2;
    !scan_start [*2];
  endsequence

  // Reset checks run while rst is high, so they opt out of the default disable
  thresh_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> words[ES_IDX_THRESHOLD] == ES_RST_THRESHOLD)
    else $error("threshold reset value wrong");
  thresh_snap_a: assert property (s_start |=>
    scan_cfg.error_count_threshold == $past(words[ES_IDX_THRESHOLD]))
    else $error("threshold not captured");
  write_land_a: assert property (reg_wr_en && reg_addr == ES_ADDR_THRESHOLD |=>
    words[ES_IDX_THRESHOLD] == $past(reg_wr_data))
    else $error("threshold write not stored");

  // Points are judged against the snapshot, never the live word
  point_class_a: assert property (err_valid |=> point_valid
    && point_bad == ($past(err_count) > $past(scan_cfg.error_count_threshold)))
    else $error("point classification wrong");
  point_hold_a: assert property (!err_valid |=> !point_valid && $stable(point_bad))
    else $error("point outputs moved without a point");

  slice_write_a: assert property (reg_wr_en && reg_addr == ES_ADDR_SLICE_INIT
    ##1 scan_start |=> scan_cfg.default_vertical_slice
    == $past(reg_wr_data[ES_SLICE_LSB +: 8], 2))
    else $error("slice write not taken");
  slice_snap_a: assert property (s_start |=>
    scan_cfg.default_vertical_slice == $past(words[ES_IDX_SLICE_INIT][ES_SLICE_LSB +: 8]))
    else $error("slice not captured");
  slice_map_a: assert property (s_start |=>
    slice_level == (scan_cfg.default_vertical_slice ^ ES_SLICE_ZERO))
    else $error("slice level mapping wrong");
  slice_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> words[ES_IDX_SLICE_INIT] == ES_RST_SLICE_INIT && !eye_init)
    else $error("slice word reset wrong");

  phase_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> words[ES_IDX_PHASE_RANGE] == ES_RST_PHASE_RANGE)
    else $error("phase range reset wrong");
  phase_first_a: assert property (s_start |=>
    scan_cfg.phase_first == $past(words[ES_IDX_PHASE_RANGE][ES_PHASE_FIRST_LSB +: 7]))
    else $error("phase start not captured");
  phase_last_a: assert property (s_start |=>
    scan_cfg.phase_last == $past(words[ES_IDX_PHASE_RANGE][ES_PHASE_LAST_LSB +: 7]))
    else $error("phase limit not captured");
  step_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> words[ES_IDX_PHASE_STEP] == ES_RST_PHASE_STEP
    && words[ES_IDX_VERT_LIMIT][ES_VERT_STEP_LSB +: 7]
    == ES_RST_VERT_LIMIT[ES_VERT_STEP_LSB +: 7])
    else $error("step reset wrong");
  phase_step_a: assert property (s_start |=>
    scan_cfg.phase_increment == $past(words[ES_IDX_PHASE_STEP][ES_PHASE_STEP_LSB +: 7]))
    else $error("phase step not captured");

  vert_range_a: assert property (s_start |=>
    scan_cfg.vertical_sweep_last == $past(words[ES_IDX_VERT_LIMIT][ES_VERT_LAST_LSB +: 8])
    && scan_cfg.vertical_sweep_first
    == $past(words[ES_IDX_PHASE_STEP][ES_VERT_FIRST_LSB +: 7]))
    else $error("vertical range not captured");
  vert_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> words[ES_IDX_VERT_LIMIT][ES_VERT_LAST_LSB +: 8]
    == ES_RST_VERT_LIMIT[ES_VERT_LAST_LSB +: 8])
    else $error("vertical limit reset wrong");
  vert_step_a: assert property (s_start |=>
    scan_cfg.vertical_sweep_increment
    == $past(words[ES_IDX_VERT_LIMIT][ES_VERT_STEP_LSB +: 7]))
    else $error("vertical step not captured");

  shape_mode_a: assert property (s_start |=>
    scan_cfg.shape_mode == $past(words[ES_IDX_SCAN_MODE][ES_SHAPE_BIT]))
    else $error("mode bit not captured");

  // Host writes between starts must never reach the running scan
  cfg_hold_a: assert property (s_start ##1 s_quiet2 |-> $stable(scan_cfg))
    else $error("snapshot moved during scan");
  snap_only_a: assert property (!scan_start |=>
    $stable(scan_cfg) && $stable(slice_level))
    else $error("snapshot moved without a start");

  read_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  read_idle_a: assert property (!reg_rd_en |=> !reg_rd_valid && $stable(reg_rd_data))
    else $error("read outputs moved without a read");

endmodule // es_eye_scan_config_regs

`default_nettype wire

/* es_eye_scan_config_regs_tb.sv */
// Purpose: self-checking bench for the eye scan configuration registers
// Assumes: one-cycle read answer and one-cycle snapshot, as handed over
// Notes: inputs move on the falling edge so every rising edge sees settled values
`timescale 1ns/1ps
`default_nettype none

module es_eye_scan_config_regs_tb;
  import es_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [15:0] reg_wr_data = 16'h0000;
  logic reg_rd_en = 1'b0;
  logic scan_start = 1'b0;
  logic err_valid = 1'b0;
  logic [15:0] err_count = 16'h0000;
  logic [15:0] reg_rd_data;
  logic reg_rd_valid, eye_init, point_valid, point_bad;
  logic [7:0] slice_level;
  es_scan_cfg_s scan_cfg;
  es_scan_cfg_s exp_cfg;
  int err_total = 0;
  int n_checks = 0;

  es_eye_scan_config_regs i_es_eye_scan_config_regs (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .scan_start(scan_start), .err_valid(err_valid), .err_count(err_count),
    .eye_init(eye_init), .scan_cfg(scan_cfg), .slice_level(slice_level),
    .point_valid(point_valid), .point_bad(point_bad));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [71:0] seen, input logic [71:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // Strobes stay up across back-to-back calls; idle drops them
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] want);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    chk(reg_rd_valid, 1'b1);
    chk(reg_rd_data, want);
  endtask

  task automatic idle();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    scan_start = 1'b0;
    err_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic reset_values();
    logic [15:0] want;
    for (int a = 8'h55; a <= 8'h5e; a++) begin
      want = (a >= 8'h56 && a <= 8'h5d) ? ES_RESET_WORDS[a - 8'h56] : 16'h0000;
      rd(a[7:0], want);
    end
    idle();
    chk(reg_rd_valid, 1'b0);
    chk(eye_init, 1'b0);
    chk(scan_cfg, 68'h0);
  endtask

  task automatic program_and_read();
    wr(8'h57, 16'h4006);
    wr(8'h56, 16'h0123);
    wr(8'h5c, 16'hff04);
    wr(8'h5d, 16'h0100);
    idle();
    chk(eye_init, 1'b1);
    rd(8'h57, 16'h4006);
    rd(8'h56, 16'h0123);
    rd(8'h5c, 16'hff04);
    rd(8'h5d, 16'h0100);
    rd(8'h58, 16'hd982);
    idle();
  endtask

  task automatic scan_and_classify();
    exp_cfg = '{1'b1, 16'h0123, 8'h40, 7'h00, 7'h7f, 7'h01, 7'h00, 8'hff, 7'h04};
    scan_start = 1'b1;
    @(negedge clk);
    scan_start = 1'b0;
    chk(scan_cfg, exp_cfg);
    chk(slice_level, 8'hc0);
    // Writes after the start must not reach the running scan
    // custom ranges, step one
    wr(8'h56, 16'h0fff);
    wr(8'h5d, 16'h0000);
    wr(8'h5a, 16'h1020);
    wr(8'h5b, 16'h0105);
    wr(8'h5c, 16'h9001);
    idle();
    chk(scan_cfg, exp_cfg);
    rd(8'h5a, 16'h1020);
    rd(8'h5b, 16'h0105);
    rd(8'h5c, 16'h9001);
    idle();
    err_valid = 1'b1;
    err_count = 16'h0123;
    @(negedge clk);
    chk({point_valid, point_bad}, 2'b10);
    err_count = 16'h0124;
    @(negedge clk);
    chk({point_valid, point_bad}, 2'b11);
    idle();
    chk({point_valid, point_bad}, 2'b01);
    // top slice code, reserved bits kept
    wr(8'h57, 16'hff06);
    reg_wr_en = 1'b0;
    scan_start = 1'b1;
    err_valid = 1'b1;
    @(negedge clk);
    // A point taken on the start edge is judged by the old snapshot
    chk({point_valid, point_bad}, 2'b11);
    scan_start = 1'b0;
    @(negedge clk);
    exp_cfg = '{1'b0, 16'h0fff, 8'hff, 7'h10, 7'h20, 7'h01, 7'h05, 8'h90, 7'h01};
    chk(scan_cfg, exp_cfg);
    chk(slice_level, 8'h7f);
    chk({point_valid, point_bad}, 2'b10);
    idle();
    chk({point_valid, point_bad}, 2'b00);
  endtask

  task automatic reset_again();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(scan_cfg, 68'h0);
    chk(slice_level, 8'h00);
    chk({point_valid, point_bad}, 2'b00);
    chk(eye_init, 1'b0);
    rd(8'h56, 16'h0064);
    rd(8'h57, 16'h8002);
    rd(8'h5a, 16'h007f);
    rd(8'h5b, 16'h0100);
    rd(8'h5c, 16'hff01);
    idle();
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reset_values();
    program_and_read();
    scan_and_classify();
    reset_again();
    summarize();
  end
endmodule // es_eye_scan_config_regs_tb

`default_nettype wire
